/* File: hdl/coil_params.svh */
`ifndef COIL_PARAMS_SVH
`define COIL_PARAMS_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define CTRL_OFF 8'h00
`define STAT_OFF 8'h04

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_SRC_BIT 0
`define CTRL_THREE_BIT 1
`define CTRL_REQ_LSB 4
`define CTRL_RESET 32'h0000_0023

// ****************************************************************
// status register fields
// ****************************************************************
`define STAT_COIL_LSB 0
`define STAT_PEND_BIT 2
`define STAT_OVR_BIT 3
`define STAT_LSPD_BIT 4
`define STAT_SPD2_BIT 5
`define STAT_PLC_BIT 6

// ****************************************************************
// bus responses
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/coil_pkg.sv */
package coil_pkg;

  typedef enum logic [1:0] {
    COIL_LOW,
    COIL_MID,
    COIL_HIGH
  } coil_e;

  typedef struct packed {
    logic plc_coil_override;
    logic low_coil_select;
    logic mid_coil_select;
    logic low_speed_detect;
    logic second_speed_detect;
  } pins_s;

endpackage

/* File: hdl/spindle_coil_changeover.sv */
`include "coil_params.svh"

module spindle_coil_changeover (
  input wire logic aclk,
  input wire logic aresetn,
  input wire coil_pkg::pins_s pins,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic low_coil_active,
  output logic mid_coil_active
);
  import coil_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  function automatic coil_e sel_to_coil(input logic low_sel,
                                        input logic mid_sel,
                                        input logic three);
    if (low_sel) begin
      sel_to_coil = COIL_LOW;
    end else if (mid_sel && three) begin
      sel_to_coil = COIL_MID;
    end else begin
      sel_to_coil = COIL_HIGH;
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // pins are slow PLC levels: a change counts once stages 2 and 3 agree
  pins_s sync1_r;
  pins_s sync2_r;
  pins_s sync3_r;
  pins_s pin_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pin_r <= sync3_r;
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [31:0] ctrl_r;
  wire src_internal = ctrl_r[`CTRL_SRC_BIT];
  wire three_coil = ctrl_r[`CTRL_THREE_BIT];
  wire [1:0] int_req = ctrl_r[`CTRL_REQ_LSB +: 2];

  // ****************************************************************
  // coil target selection
  // ****************************************************************
  wire coil_e plc_tgt = sel_to_coil(pin_r.low_coil_select,
                                    pin_r.mid_coil_select, three_coil);
  wire coil_e int_tgt = sel_to_coil(int_req == 2'h0,
                                    int_req == 2'h1, three_coil);
  // selects are assumed settled before override rises, so no extra
  // qualification of the PLC path is done here
  wire use_plc = !src_internal || pin_r.plc_coil_override;
  wire coil_e tgt = use_plc ? plc_tgt : int_tgt;

  // ****************************************************************
  // changeover sequencing
  // ****************************************************************
  coil_e coil_r;
  coil_e coil_nxt;
  wire going_up = (tgt > coil_r);
  wire to_low = (tgt == COIL_LOW) && (coil_r != COIL_LOW);
  wire to_mid = (tgt == COIL_MID) && (coil_r == COIL_HIGH);
  wire down_ok = (to_low && pin_r.low_speed_detect) ||
                 (to_mid && pin_r.second_speed_detect);
  wire pending = (to_low || to_mid) && !down_ok;

  always_comb begin
    coil_nxt = coil_r;
    if (going_up) begin
      coil_nxt = tgt;
    end else if (down_ok) begin
      coil_nxt = tgt;
    end
  end

  logic low_act_r;
  logic mid_act_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_r <= COIL_HIGH;
      low_act_r <= 1'b0;
      mid_act_r <= 1'b0;
    end else begin
      coil_r <= coil_nxt;
      low_act_r <= (coil_nxt == COIL_LOW);
      mid_act_r <= (coil_nxt == COIL_MID);
    end
  end

  assign low_coil_active = low_act_r;
  assign mid_coil_active = mid_act_r;

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_fire = awvalid && awready_r;
  wire w_fire = wvalid && wready_r;
  wire aw_have = aw_got_r || aw_fire;
  wire w_have = w_got_r || w_fire;
  wire [7:0] wr_addr = aw_got_r ? aw_addr_r : awaddr;
  wire [31:0] wr_data = w_got_r ? w_data_r : wdata;
  wire [3:0] wr_strb = w_got_r ? w_strb_r : wstrb;
  wire wr_go = aw_have && w_have && !bvalid_r;
  wire wr_ctrl = wr_go && reg_hit(wr_addr, `CTRL_OFF);
  wire wr_stat = wr_go && reg_hit(wr_addr, `STAT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      aw_got_r <= aw_have && !wr_go;
      w_got_r <= w_have && !wr_go;
      if (aw_fire) begin
        aw_addr_r <= awaddr;
      end
      if (w_fire) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
    end
  end

  // ready drops once an item is held, until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      awready_r <= !aw_have && !(bvalid_r && !bready) && !wr_go;
      wready_r <= !w_have && !(bvalid_r && !bready) && !wr_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wr_ctrl || wr_stat) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // only byte 0 carries control fields; status writes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ctrl && wr_strb[0]) begin
      ctrl_r <= {24'h00_0000, 2'h0, wr_data[5:4], 2'h0, wr_data[1:0]};
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_fire = arvalid && arready_r;
  wire rd_ctrl = reg_hit(araddr, `CTRL_OFF);
  wire rd_stat = reg_hit(araddr, `STAT_OFF);
  wire [31:0] stat_word = {25'h000_0000, use_plc,
                           pin_r.second_speed_detect,
                           pin_r.low_speed_detect,
                           pin_r.plc_coil_override, pending, coil_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else begin
      arready_r <= !rvalid_r && !ar_fire;
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rresp_r <= (rd_ctrl || rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
        if (rd_ctrl) begin
          rdata_r <= ctrl_r;
        end else if (rd_stat) begin
          rdata_r <= stat_word;
        end else begin
          rdata_r <= 32'h0000_0000;
        end
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_hold_high_to_mid;
    coil_r == COIL_HIGH && tgt == COIL_MID && !pin_r.second_speed_detect;
  endsequence

  sequence s_speed_arrives;
    coil_r == COIL_HIGH && tgt == COIL_MID && pin_r.second_speed_detect;
  endsequence

  sequence s_write_pair;
    aw_have && w_have && !bvalid_r;
  endsequence

  AST_OVERRIDE_PLC: assert property (
    src_internal && pin_r.plc_coil_override |-> tgt == plc_tgt)
    else $error("override did not hand selection to plc");

  AST_SOURCE_PLC: assert property (
    !src_internal |-> tgt == plc_tgt)
    else $error("source bit 0 did not select plc");

  AST_UP_IMMEDIATE: assert property (
    coil_r < tgt |=> coil_r == $past(tgt))
    else $error("faster coil not taken at once");

  AST_LOW_HELD: assert property (
    to_low && !pin_r.low_speed_detect |=> coil_r == $past(coil_r))
    else $error("slow-down to low coil not held");

  AST_LOW_DONE: assert property (
    to_low && pin_r.low_speed_detect |=> coil_r == COIL_LOW &&
      low_coil_active)
    else $error("low coil not reached after speed detect");

  AST_MID_HELD: assert property (
    s_hold_high_to_mid |=> coil_r == COIL_HIGH && !mid_coil_active)
    else $error("high to middle not held");

  AST_MID_DONE: assert property (
    s_speed_arrives |=> coil_r == COIL_MID && mid_coil_active)
    else $error("middle coil not reached after second detect");

  AST_RELEASE_INTERNAL: assert property (
    src_internal && !pin_r.plc_coil_override |-> tgt == int_tgt)
    else $error("internal process not in charge without override");

  AST_ACTIVE_MATCH: assert property (
    !(low_coil_active && mid_coil_active) &&
    low_coil_active == (coil_r == COIL_LOW))
    else $error("active outputs disagree with coil in use");

  AST_WRITE_RESP: assert property (
    s_write_pair |=> bvalid_r && !awready_r && !wready_r)
    else $error("write pair got no response");

  AST_BVALID_STANDS: assert property (
    bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before it was taken");

  AST_RVALID_STANDS: assert property (
    rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped before it was taken");

endmodule

/* File: verif/plc_model.sv */
// ****************************************
// plc sequence and drive detect outputs
// ****************************************
module plc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire coil_pkg::coil_e want_coil,
  input wire logic want_ovr,
  input wire logic spd_low,
  input wire logic spd2,
  output coil_pkg::pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import coil_pkg::*;
  logic low_r, mid_r, ovr_r;
  wire low_nxt = (want_coil == COIL_LOW);
  wire mid_nxt = (want_coil == COIL_MID);
  // override waits one edge so the selects are already stable
  wire settled = (low_r == low_nxt) && (mid_r == mid_nxt);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_r <= 1'h0;
      mid_r <= 1'h0;
      ovr_r <= 1'h0;
    end else begin
      low_r <= low_nxt;
      mid_r <= mid_nxt;
      ovr_r <= want_ovr && (ovr_r || settled);
    end
  end
  assign pins = {ovr_r, low_r, mid_r, spd_low, spd2};
endmodule

/* File: verif/spindle_coil_changeover_bench.sv */
`include "coil_params.svh"
module spindle_coil_changeover_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import coil_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic low_coil_active, mid_coil_active, want_ovr, spd_low, spd2;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, wb;
  coil_e want_coil;
  pins_s pins;
  int n_errors = 0;
  int comparisons = 0;
  wire [1:0] act = {low_coil_active, mid_coil_active};

  spindle_coil_changeover spindle_coil_changeover_inst (
    .aclk(aclk), .aresetn(aresetn), .pins(pins),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .low_coil_active(low_coil_active), .mid_coil_active(mid_coil_active)
  );
  plc_model plc_model_inst (
    .aclk(aclk), .aresetn(aresetn), .want_coil(want_coil),
    .want_ovr(want_ovr), .spd_low(spd_low), .spd2(spd2), .pins(pins)
  );

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  function automatic logic [1:0] enc(input coil_e c);
    return (c == COIL_LOW) ? 2'h2 : (c == COIL_MID) ? 2'h1 : 2'h0;
  endfunction

  task final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    comparisons++;
    if (seen !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task tmo;
    n_errors++;
    final_report();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] dv);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        wb = bresp;
        break;
      end
    end
    bready <= 1'h0;
    if (i == 50) tmo();
  endtask

  task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    dv = rdata;
    rv = rresp;
    rready <= 1'h0;
    if (i == 50) tmo();
  endtask

  // outputs are sampled on the falling edge, well settled
  task wait_coil(input coil_e c, input string nm);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge aclk);
      if (act === enc(c)) break;
    end
    check(nm, act, enc(c));
    @(posedge aclk);
  endtask

  task hold_coil(input coil_e c, input string nm);
    int bad;
    bad = 0;
    repeat (12) begin
      @(negedge aclk);
      if (act !== enc(c)) bad++;
    end
    check(nm, bad, 0);
    @(posedge aclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    check("act_rst", act, enc(COIL_HIGH));
    rd(`CTRL_OFF, d, r);
    check("ctrl_rst", d, `CTRL_RESET);
    check("ctrl_rresp", r, `RESP_OKAY);
    rd(8'h08, d, r);
    check("unmapped", r, `RESP_SLVERR);
    wr(8'h08, 32'h0000_0000);
    check("wr_unmapped", wb, `RESP_SLVERR);
    wr(`STAT_OFF, 32'h0000_0000);
    check("wr_stat", wb, `RESP_OKAY);
  endtask

  task t_three;
    wr(`CTRL_OFF, 32'h03);
    check("wr_ctrl", wb, `RESP_OKAY);
    hold_coil(COIL_HIGH, "h2l_hold");
    rd(`STAT_OFF, d, r);
    check("stat_pend", d, 32'h0000_0006);
    spd_low <= 1'h1;
    wait_coil(COIL_LOW, "h2l");
    spd_low <= 1'h0;
    wr(`CTRL_OFF, 32'h13);
    wait_coil(COIL_MID, "l2m");
    wr(`CTRL_OFF, 32'h23);
    wait_coil(COIL_HIGH, "m2h");
    wr(`CTRL_OFF, 32'h13);
    hold_coil(COIL_HIGH, "h2m_hold");
    spd2 <= 1'h1;
    wait_coil(COIL_MID, "h2m");
    spd2 <= 1'h0;
    wr(`CTRL_OFF, 32'h03);
    hold_coil(COIL_MID, "m2l_hold");
    spd_low <= 1'h1;
    wait_coil(COIL_LOW, "m2l");
    wr(`CTRL_OFF, 32'h23);
    wait_coil(COIL_HIGH, "l2h_three");
  endtask

  task t_two;
    spd_low <= 1'h0;
    // let the filtered detect fall before asking for the slower coil
    repeat (6) @(posedge aclk);
    wr(`CTRL_OFF, 32'h01);
    hold_coil(COIL_HIGH, "two_h2l_hold");
    spd_low <= 1'h1;
    wait_coil(COIL_LOW, "two_h2l");
    wr(`CTRL_OFF, 32'h21);
    wait_coil(COIL_HIGH, "two_l2h");
    wr(`CTRL_OFF, 32'h11);
    hold_coil(COIL_HIGH, "two_mid_req");
  endtask

  task t_ovr;
    wr(`CTRL_OFF, 32'h03);
    wait_coil(COIL_LOW, "int_low");
    want_ovr <= 1'h1;
    wait_coil(COIL_HIGH, "ovr_on");
    want_ovr <= 1'h0;
    wait_coil(COIL_LOW, "ovr_off");
  endtask

  task t_plc;
    wr(`CTRL_OFF, 32'h02);
    wait_coil(COIL_HIGH, "plc_src");
    want_coil <= COIL_MID;
    spd2 <= 1'h1;
    wait_coil(COIL_MID, "plc_mid");
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {want_ovr, spd_low, spd2} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    want_coil = COIL_HIGH;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_three();
    t_two();
    t_ovr();
    t_plc();
    final_report();
  end
endmodule
